// File: hw/rsx_map.svh
`ifndef RSX_MAP_SVH
`define RSX_MAP_SVH

// ----------------------------------------------------------------
// Constants of the execution block
// ----------------------------------------------------------------
`define RSX_DATA_W       8
`define RSX_PC_W         13
`define RSX_ALL_ONES     8'hFF
`define RSX_ACC_RST      8'h00
`define RSX_FLAG_RST     1'b0
`define RSX_GIE_RST      1'b0
`define RSX_SKIP_CYCLES  2
`define RSX_PLAIN_CYCLES 1

`endif

// File: hw/rsx_pkg.sv
`default_nettype none

package rsx_pkg;

  // ----------------------------------------------------------------
  // Operation codes presented on op_i
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    RSX_OP_NONE                       = 5'h00,
    RSX_OP_RETURN_FROM_INTERRUPT      = 5'h01,
    RSX_OP_ROTATE_LEFT                = 5'h02,
    RSX_OP_ROTATE_LEFT_TO_ACC         = 5'h03,
    RSX_OP_ROTATE_LEFT_THROUGH_CARRY  = 5'h04,
    RSX_OP_ROTATE_LEFT_CARRY_TO_ACC   = 5'h05,
    RSX_OP_ROTATE_RIGHT               = 5'h06,
    RSX_OP_ROTATE_RIGHT_TO_ACC        = 5'h07,
    RSX_OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h08,
    RSX_OP_ROTATE_RIGHT_CARRY_TO_ACC  = 5'h09,
    RSX_OP_SUBTRACT_WITH_BORROW       = 5'h0A,
    RSX_OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h0B,
    RSX_OP_DECREMENT_SKIP_ZERO        = 5'h0C,
    RSX_OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h0D,
    RSX_OP_SET_BYTE                   = 5'h0E,
    RSX_OP_SET_BIT                    = 5'h0F,
    RSX_OP_INCREMENT_SKIP_ZERO        = 5'h10,
    RSX_OP_INCREMENT_SKIP_ZERO_TO_ACC = 5'h11,
    RSX_OP_SKIP_IF_BIT_SET            = 5'h12
  } rsx_op_e;

  // Sequencer states
  typedef enum logic {
    RSX_ST_EXEC,
    RSX_ST_DUMMY
  } rsx_state_e;

endpackage : rsx_pkg

`default_nettype wire

// File: hw/rsx_sub_borrow.sv
`default_nettype none
`include "rsx_map.svh"

// ------------------------------------------------------------------
// Adder for accumulator plus complemented operand plus carry
// ------------------------------------------------------------------
module rsx_sub_borrow #(
  parameter int W = `RSX_DATA_W
) (
  // Operands
  input  wire logic [W-1:0] acc_i,   // Minuend
  input  wire logic [W-1:0] mem_i,   // Subtrahend
  input  wire logic         cy_i,    // Carry in, one means no borrow
  // Result
  output logic      [W-1:0] sum_o,   // Difference
  output logic              cy_o,    // Carry out, one means no borrow
  output logic              ac_o,    // Carry out of the low nibble
  output logic              ov_o     // Signed overflow
);

  // Refuse widths narrower than one 8-bit byte
  if (W < 8) begin : g_bad_w
    $error("rsx_sub_borrow needs W of at least 8");
  end

  wire logic [W-1:0] inv_w = ~mem_i;                             // One's complement
  wire logic [W:0]   full_w = {1'b0, acc_i} + {1'b0, inv_w} + {{W{1'b0}}, cy_i};
  wire logic [4:0]   nib_w = {1'b0, acc_i[3:0]} + {1'b0, inv_w[3:0]} + {4'h0, cy_i};

  assign sum_o = full_w[W-1:0];
  assign cy_o  = full_w[W];
  assign ac_o  = nib_w[4];
  // Overflow when both addends share a sign the result lacks
  assign ov_o  = (acc_i[W-1] == inv_w[W-1]) && (sum_o[W-1] != acc_i[W-1]);

endmodule : rsx_sub_borrow

`default_nettype wire

// File: hw/rsx_core.sv
`default_nettype none
`include "rsx_map.svh"

module rsx_core #(
  parameter int DW  = `RSX_DATA_W,   // Data width
  parameter int PCW = `RSX_PC_W      // Program counter width
) (
  // Clock and reset
  input  wire logic            clk_i,        // Instruction clock
  input  wire logic            nrst_i,       // Async reset, active low
  // Instruction issue
  input  wire logic            issue_i,      // Instruction valid this cycle
  input  wire logic [4:0]      op_i,         // Operation code
  input  wire logic [2:0]      bit_sel_i,    // Bit index for bit ops
  input  wire logic [DW-1:0]   mem_rdata_i,  // Addressed memory byte
  input  wire logic [PCW-1:0]  stack_top_i,  // Top of hardware stack
  // Flag inputs kept by the surrounding core
  input  wire logic            to_flag_i,    // Timeout flag, passed through
  input  wire logic            pd_flag_i,    // Power-down flag, passed through
  // Memory write back
  output logic                 mem_we_o,     // One-cycle write strobe
  output logic      [DW-1:0]   mem_wdata_o,  // Write data
  // Program flow
  output logic                 pc_load_o,    // One-cycle PC reload strobe
  output logic      [PCW-1:0]  pc_value_o,   // PC reload value
  output logic                 stack_pop_o,  // One-cycle stack pop
  output logic                 discard_o,    // Prefetch discarded, dummy cycle
  output logic                 busy_o,       // Not ready for issue
  // Architectural state
  output logic      [DW-1:0]   acc_o,        // Accumulator
  output logic                 carry_flag_o,
  output logic                 auxiliary_carry_flag_o,
  output logic                 zero_flag_o,
  output logic                 overflow_flag_o,
  output logic                 timeout_flag_o,
  output logic                 power_down_flag_o,
  output logic                 global_interrupt_enable_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DW != 8) begin : g_bad_dw
    $error("rsx_core supports only an 8-bit datapath");
  end
  if (PCW < 1) begin : g_bad_pcw
    $error("rsx_core needs a nonzero PC width");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  rsx_pkg::rsx_state_e state_q, state_d;

  // Issue only taken while not inserting a dummy cycle
  wire logic go_w = issue_i && (state_q == rsx_pkg::RSX_ST_EXEC);
  wire logic [4:0] op_w = go_w ? op_i : 5'h00;

  wire logic is_return_from_interrupt_w  = op_w == rsx_pkg::RSX_OP_RETURN_FROM_INTERRUPT;
  wire logic is_rl_w    = op_w == rsx_pkg::RSX_OP_ROTATE_LEFT;
  wire logic is_rla_w   = op_w == rsx_pkg::RSX_OP_ROTATE_LEFT_TO_ACC;
  wire logic is_rlc_w   = op_w == rsx_pkg::RSX_OP_ROTATE_LEFT_THROUGH_CARRY;
  wire logic is_rotate_left_carry_to_acc_w  = op_w == rsx_pkg::RSX_OP_ROTATE_LEFT_CARRY_TO_ACC;
  wire logic is_rr_w    = op_w == rsx_pkg::RSX_OP_ROTATE_RIGHT;
  wire logic is_rra_w   = op_w == rsx_pkg::RSX_OP_ROTATE_RIGHT_TO_ACC;
  wire logic is_rrc_w   = op_w == rsx_pkg::RSX_OP_ROTATE_RIGHT_THROUGH_CARRY;
  wire logic is_rotate_right_carry_to_acc_w  = op_w == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_ACC;
  wire logic is_sb_w    = op_w == rsx_pkg::RSX_OP_SUBTRACT_WITH_BORROW;
  wire logic is_sbm_w   = op_w == rsx_pkg::RSX_OP_SUBTRACT_WITH_BORROW_TO_MEM;
  wire logic is_dz_w    = op_w == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO;
  wire logic is_dza_w   = op_w == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO_TO_ACC;
  wire logic is_setb_w  = op_w == rsx_pkg::RSX_OP_SET_BYTE;
  wire logic is_setbit_w = op_w == rsx_pkg::RSX_OP_SET_BIT;
  wire logic is_iz_w    = op_w == rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO;
  wire logic is_iza_w   = op_w == rsx_pkg::RSX_OP_INCREMENT_SKIP_ZERO_TO_ACC;
  wire logic is_snz_w   = op_w == rsx_pkg::RSX_OP_SKIP_IF_BIT_SET;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire logic [DW-1:0] m_w = mem_rdata_i;

  // Plain rotates wrap the end bit round
  wire logic [DW-1:0] rol_w  = {m_w[DW-2:0], m_w[DW-1]};
  wire logic [DW-1:0] ror_w  = {m_w[0], m_w[DW-1:1]};
  // Nine-bit rotates take the old carry in
  wire logic [DW-1:0] rolc_w = {m_w[DW-2:0], carry_flag_o};
  wire logic [DW-1:0] rorc_w = {carry_flag_o, m_w[DW-1:1]};

  // Decrement and increment share no adder; both are small
  wire logic [DW-1:0] dec_w = m_w - {{(DW-1){1'b0}}, 1'b1};
  wire logic [DW-1:0] inc_w = m_w + {{(DW-1){1'b0}}, 1'b1};
  wire logic          dec_zero_w = (dec_w == '0);
  wire logic          inc_zero_w = (inc_w == '0);

  // Bit set mask from the bit index
  wire logic [DW-1:0] bit_mask_w = {{(DW-1){1'b0}}, 1'b1} << bit_sel_i;
  wire logic [DW-1:0] setbit_w   = m_w | bit_mask_w;
  wire logic          bit_one_w  = |(m_w & bit_mask_w);

  // Subtract with borrow result and flags
  logic [DW-1:0] sb_sum_w;
  logic          sb_cy_w;
  logic          sb_ac_w;
  logic          sb_ov_w;

  rsx_sub_borrow #(
    .W      (DW)
  ) u_sub (
    .acc_i  (acc_o),
    .mem_i  (m_w),
    .cy_i   (carry_flag_o),
    .sum_o  (sb_sum_w),
    .cy_o   (sb_cy_w),
    .ac_o   (sb_ac_w),
    .ov_o   (sb_ov_w)
  );

  // ----------------------------------------------------------------
  // Destination selects
  // ----------------------------------------------------------------
  // Memory is written only by the memory-destination forms
  wire logic mem_we_w = is_rl_w | is_rlc_w | is_rr_w | is_rrc_w | is_sbm_w
                      | is_dz_w | is_iz_w | is_setb_w | is_setbit_w;

  wire logic [DW-1:0] mem_wd_w =
      is_rl_w     ? rol_w    :
      is_rlc_w    ? rolc_w   :
      is_rr_w     ? ror_w    :
      is_rrc_w    ? rorc_w   :
      is_sbm_w    ? sb_sum_w :
      is_dz_w     ? dec_w    :
      is_iz_w     ? inc_w    :
      is_setb_w   ? `RSX_ALL_ONES :
      is_setbit_w ? setbit_w : mem_wdata_o;

  // Accumulator forms never touch memory
  wire logic acc_we_w = is_rla_w | is_rotate_left_carry_to_acc_w | is_rra_w | is_rotate_right_carry_to_acc_w | is_sb_w
                      | is_dza_w | is_iza_w;

  wire logic [DW-1:0] acc_wd_w =
      is_rla_w  ? rol_w    :
      is_rotate_left_carry_to_acc_w ? rolc_w   :
      is_rra_w  ? ror_w    :
      is_rotate_right_carry_to_acc_w ? rorc_w   :
      is_sb_w   ? sb_sum_w :
      is_dza_w  ? dec_w    :
      is_iza_w  ? inc_w    : acc_o;

  // Carry from the bit shifted out, or from the subtractor
  wire logic rot_left_c_w  = is_rlc_w | is_rotate_left_carry_to_acc_w;
  wire logic rot_right_c_w = is_rrc_w | is_rotate_right_carry_to_acc_w;
  wire logic sub_any_w     = is_sb_w | is_sbm_w;

  wire logic carry_d_w =
      rot_left_c_w  ? m_w[DW-1] :
      rot_right_c_w ? m_w[0]    :
      sub_any_w     ? sb_cy_w   : carry_flag_o;

  // Only subtract moves the other arithmetic flags
  wire logic ac_d_w = sub_any_w ? sb_ac_w : auxiliary_carry_flag_o;
  wire logic ov_d_w = sub_any_w ? sb_ov_w : overflow_flag_o;
  wire logic z_d_w  = sub_any_w ? (sb_sum_w == '0) : zero_flag_o;

  // Skip conditions
  wire logic skip_w = ((is_dz_w | is_dza_w) & dec_zero_w)
                    | ((is_iz_w | is_iza_w) & inc_zero_w)
                    | (is_snz_w & bit_one_w);

  // ----------------------------------------------------------------
  // Sequencer: one execute cycle, plus a dummy cycle on a skip
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rsx_pkg::RSX_ST_EXEC: begin
        if (skip_w) begin
          state_d = rsx_pkg::RSX_ST_DUMMY;
        end
      end
      rsx_pkg::RSX_ST_DUMMY: begin
        state_d = rsx_pkg::RSX_ST_EXEC;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= rsx_pkg::RSX_ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Accumulator and arithmetic flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_o                  <= `RSX_ACC_RST;
      carry_flag_o           <= `RSX_FLAG_RST;
      auxiliary_carry_flag_o <= `RSX_FLAG_RST;
      zero_flag_o            <= `RSX_FLAG_RST;
      overflow_flag_o        <= `RSX_FLAG_RST;
    end else begin
      if (acc_we_w) begin
        acc_o <= acc_wd_w;
      end
      carry_flag_o           <= carry_d_w;
      auxiliary_carry_flag_o <= ac_d_w;
      zero_flag_o            <= z_d_w;
      overflow_flag_o        <= ov_d_w;
    end
  end

  // Timeout and power-down are owned outside; mirrored registered, never changed here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timeout_flag_o    <= `RSX_FLAG_RST;
      power_down_flag_o <= `RSX_FLAG_RST;
    end else begin
      timeout_flag_o    <= to_flag_i;
      power_down_flag_o <= pd_flag_i;
    end
  end

  // Global interrupt enable, set by interrupt return
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      global_interrupt_enable_o <= `RSX_GIE_RST;
    end else if (is_return_from_interrupt_w) begin
      global_interrupt_enable_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Strobes and write data
  // ----------------------------------------------------------------
  // Memory write strobe and data, one cycle after issue
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_we_o    <= 1'b0;
      mem_wdata_o <= '0;
    end else begin
      mem_we_o    <= mem_we_w;
      mem_wdata_o <= mem_wd_w;
    end
  end

  // PC reload from stack top on interrupt return
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc_load_o   <= 1'b0;
      stack_pop_o <= 1'b0;
      pc_value_o  <= '0;
    end else begin
      pc_load_o   <= is_return_from_interrupt_w;
      stack_pop_o <= is_return_from_interrupt_w;
      if (is_return_from_interrupt_w) begin
        pc_value_o <= stack_top_i;
      end
    end
  end

  // Discard flag marks the dummy cycle; busy blocks issue during it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      discard_o <= 1'b0;
      busy_o    <= 1'b0;
    end else begin
      discard_o <= (state_d == rsx_pkg::RSX_ST_DUMMY);
      busy_o    <= (state_d == rsx_pkg::RSX_ST_DUMMY);
    end
  end

endmodule : rsx_core

`default_nettype wire

// File: tb/rsx_core_chk.sv
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the execution block
// ----------------------------------------------------------------
module rsx_core_chk #(
  parameter int DW  = 8,  // Data width
  parameter int PCW = 13  // Program counter width
) (
  // Clock, reset and issue
  input wire logic           clk_i,
  input wire logic           nrst_i,
  input wire logic           issue_i,
  input wire logic [4:0]     op_i,
  input wire logic [2:0]     bit_sel_i,
  input wire logic [DW-1:0]  mem_rdata_i,
  input wire logic [PCW-1:0] stack_top_i,
  input wire logic           to_flag_i,
  input wire logic           pd_flag_i,
  // Results
  input wire logic           mem_we_o,
  input wire logic [DW-1:0]  mem_wdata_o,
  input wire logic           pc_load_o,
  input wire logic [PCW-1:0] pc_value_o,
  input wire logic           stack_pop_o,
  input wire logic           discard_o,
  input wire logic           busy_o,
  input wire logic [DW-1:0]  acc_o,
  input wire logic           carry_flag_o,
  input wire logic           zero_flag_o,
  input wire logic           timeout_flag_o,
  input wire logic           power_down_flag_o,
  input wire logic           global_interrupt_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Operands of the last edge, so results tie to their cause
  logic [DW-1:0]  m_q;
  logic [PCW-1:0] st_q;
  logic [2:0]     b_q;
  logic           c_q;
  logic           rdy_q;  // Low first cycle after reset: history not valid yet

  // History capture
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {m_q, st_q, b_q, c_q, rdy_q} <= '0;
    end else begin
      {m_q, st_q, b_q, c_q, rdy_q} <= {mem_rdata_i, stack_top_i, bit_sel_i, carry_flag_o, 1'b1};
    end
  end

  // Accepted instructions by kind
  wire take  = issue_i && !busy_o && rdy_q;
  wire t_rti = take && op_i == rsx_pkg::RSX_OP_RETURN_FROM_INTERRUPT;
  wire t_rlc = take && op_i == rsx_pkg::RSX_OP_ROTATE_LEFT_THROUGH_CARRY;
  wire t_rrc = take && op_i == rsx_pkg::RSX_OP_ROTATE_RIGHT_CARRY_TO_ACC;
  wire t_sbc = take && op_i == rsx_pkg::RSX_OP_SUBTRACT_WITH_BORROW;
  wire t_sdz = take && op_i == rsx_pkg::RSX_OP_DECREMENT_SKIP_ZERO;
  wire t_set = take && op_i == rsx_pkg::RSX_OP_SET_BYTE;
  wire t_snz = take && op_i == rsx_pkg::RSX_OP_SKIP_IF_BIT_SET;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  property p_rti; t_rti |=> pc_load_o && stack_pop_o && pc_value_o == st_q && global_interrupt_enable_o; endproperty
  a_rti: assert property (p_rti) else $error("interrupt return wrong");
  property p_rlc; t_rlc |=> mem_we_o && mem_wdata_o == {m_q[DW-2:0], c_q} && carry_flag_o == m_q[DW-1]; endproperty
  a_rlc: assert property (p_rlc) else $error("left carry rotate wrong");
  property p_rrc; t_rrc |=> !mem_we_o && acc_o == {c_q, m_q[DW-1:1]} && carry_flag_o == m_q[0]; endproperty
  a_rrc: assert property (p_rrc) else $error("right carry rotate wrong");
  property p_sbc; t_sbc |=> zero_flag_o == (acc_o == '0); endproperty
  a_sbc: assert property (p_sbc) else $error("subtract zero flag wrong");
  property p_sdz; t_sdz |=> mem_we_o && mem_wdata_o == m_q - 8'h01 && discard_o == (m_q == 8'h01); endproperty
  a_sdz: assert property (p_sdz) else $error("decrement skip wrong");
  property p_set; t_set |=> mem_we_o && mem_wdata_o == 8'hFF && $stable({carry_flag_o, zero_flag_o}); endproperty
  a_set: assert property (p_set) else $error("set byte wrong");
  property p_snz; t_snz |=> discard_o == m_q[b_q] && !mem_we_o; endproperty
  a_snz: assert property (p_snz) else $error("bit skip wrong");
  property p_skp; discard_o |-> busy_o ##1 !discard_o; endproperty
  a_skp: assert property (p_skp) else $error("dummy cycle length wrong");
  property p_ref; issue_i && busy_o |=> !mem_we_o && !pc_load_o; endproperty
  a_ref: assert property (p_ref) else $error("issue taken while busy");
  property p_to; rdy_q |-> timeout_flag_o == $past(to_flag_i); endproperty
  a_to: assert property (p_to) else $error("timeout flag not mirrored");
  property p_pd; rdy_q |-> power_down_flag_o == $past(pd_flag_i); endproperty
  a_pd: assert property (p_pd) else $error("power-down flag not mirrored");
endmodule : rsx_core_chk

bind rsx_core rsx_core_chk #(.DW(DW), .PCW(PCW)) i_rsx_core_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
  .mem_rdata_i(mem_rdata_i), .stack_top_i(stack_top_i), .to_flag_i(to_flag_i), .mem_we_o(mem_we_o),
  .mem_wdata_o(mem_wdata_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .stack_pop_o(stack_pop_o),
  .discard_o(discard_o), .busy_o(busy_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o),
  .zero_flag_o(zero_flag_o), .timeout_flag_o(timeout_flag_o), .pd_flag_i(pd_flag_i),
  .power_down_flag_o(power_down_flag_o),
  .global_interrupt_enable_o(global_interrupt_enable_o)
);

`default_nettype wire

// File: tb/rotate_subtract_skip_execution_tb_top.sv
`default_nettype none

module rotate_subtract_skip_execution_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Ports of the block under test
  // ----------------------------------------------------------------
  logic        clk_i, nrst_i, issue_i, to_flag_i, pd_flag_i;
  logic [4:0]  op_i;
  logic [2:0]  bit_sel_i;
  logic [7:0]  mem_rdata_i, mem_wdata_o, acc_o;
  logic [12:0] stack_top_i, pc_value_o;
  logic        mem_we_o, pc_load_o, stack_pop_o, discard_o, busy_o, carry_flag_o, zero_flag_o;
  logic        auxiliary_carry_flag_o, overflow_flag_o, timeout_flag_o, power_down_flag_o;
  logic        global_interrupt_enable_o;

  rsx_core i_rsx_core (
    .clk_i(clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
    .mem_rdata_i(mem_rdata_i), .stack_top_i(stack_top_i), .to_flag_i(to_flag_i), .pd_flag_i(pd_flag_i),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
    .stack_pop_o(stack_pop_o), .discard_o(discard_o), .busy_o(busy_o), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o), .auxiliary_carry_flag_o(auxiliary_carry_flag_o), .zero_flag_o(zero_flag_o),
    .overflow_flag_o(overflow_flag_o), .timeout_flag_o(timeout_flag_o), .power_down_flag_o(power_down_flag_o),
    .global_interrupt_enable_o(global_interrupt_enable_o)
  );

  // Reference state, note queue and tallies
  logic [7:0]  e_acc, e_wd;
  logic [12:0] e_pcv;
  logic        e_c, e_ac, e_z, e_ov, e_gie, took;
  logic [38:0] notes[$];
  int          err_total, checks_done;

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic cmp(input logic [38:0] got, input logic [38:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp

  // Accepted issue at this edge; busy_o still shows its old value here
  always @(posedge clk_i) took <= nrst_i & issue_i & ~busy_o;

  // Outputs are settled by the falling edge; strobes only after a take
  always @(negedge clk_i) begin
    if (!took) begin
      cmp(39'({mem_we_o, discard_o, busy_o, pc_load_o, stack_pop_o}), 39'h0);
    end else if (notes.size() == 0) begin
      cmp(39'h1, 39'h0);
    end else begin
      cmp({mem_we_o, mem_wdata_o, discard_o, busy_o, pc_load_o, stack_pop_o, pc_value_o, acc_o, carry_flag_o,
           auxiliary_carry_flag_o, zero_flag_o, overflow_flag_o, global_interrupt_enable_o}, notes.pop_front());
    end
  end

  // Status flags owned elsewhere toggle freely
  always @(posedge clk_i) begin
    to_flag_i <= 1'($urandom);
    pd_flag_i <= 1'($urandom);
  end

  // Issue one instruction, note its result, try a refused issue after a skip
  task automatic run_op(input logic [4:0] op, input logic [7:0] m, input logic [2:0] b);
    logic [8:0]  r;
    logic [4:0]  n;
    logic        we, sk, pl;
    logic [12:0] st;
    we = 1'b0;
    sk = 1'b0;
    pl = 1'b0;
    st = 13'($urandom);
    case (op)
      5'h01: begin pl = 1'b1; e_pcv = st; e_gie = 1'b1; end
      5'h02: begin we = 1'b1; e_wd = {m[6:0], m[7]}; end
      5'h03: e_acc = {m[6:0], m[7]};
      5'h04: begin we = 1'b1; e_wd = {m[6:0], e_c}; e_c = m[7]; end
      5'h05: begin e_acc = {m[6:0], e_c}; e_c = m[7]; end
      5'h06: begin we = 1'b1; e_wd = {m[0], m[7:1]}; end
      5'h07: e_acc = {m[0], m[7:1]};
      5'h08: begin we = 1'b1; e_wd = {e_c, m[7:1]}; e_c = m[0]; end
      5'h09: begin e_acc = {e_c, m[7:1]}; e_c = m[0]; end
      5'h0A, 5'h0B: begin
        r = {1'b0, e_acc} + {1'b0, ~m} + 9'(e_c);
        n = {1'b0, e_acc[3:0]} + {1'b0, ~m[3:0]} + 5'(e_c);
        e_ov = (e_acc[7] == ~m[7]) && (r[7] != e_acc[7]);
        {e_c, e_ac, e_z} = {r[8], n[4], r[7:0] == 8'h00};
        if (op == 5'h0A) e_acc = r[7:0];
        else begin we = 1'b1; e_wd = r[7:0]; end
      end
      5'h0C: begin we = 1'b1; e_wd = m - 8'h01; sk = m == 8'h01; end
      5'h0D: begin e_acc = m - 8'h01; sk = m == 8'h01; end
      5'h0E: begin we = 1'b1; e_wd = 8'hFF; end
      5'h0F: begin we = 1'b1; e_wd = m | (8'h01 << b); end
      5'h10: begin we = 1'b1; e_wd = m + 8'h01; sk = m == 8'hFF; end
      5'h11: begin e_acc = m + 8'h01; sk = m == 8'hFF; end
      5'h12: sk = m[b];
      default: ;
    endcase
    notes.push_back({we, e_wd, sk, sk, pl, pl, e_pcv, e_acc, e_c, e_ac, e_z, e_ov, e_gie});
    issue_i <= 1'b1;
    op_i <= op;
    mem_rdata_i <= m;
    bit_sel_i <= b;
    stack_top_i <= st;
    @(posedge clk_i);
    if (sk) begin
      op_i <= 5'h0E;  // Held during the dummy cycle, must be ignored
      @(posedge clk_i);
    end
  endtask : run_op

  task automatic idle();
    issue_i <= 1'b0;
    @(posedge clk_i);
  endtask : idle

  // Reset for four cycles; everything reads zero meanwhile
  task automatic do_reset();
    nrst_i <= 1'b0;
    {e_acc, e_wd, e_pcv, e_c, e_ac, e_z, e_ov, e_gie} = '0;
    repeat (4) @(posedge clk_i);
    cmp(39'({acc_o, pc_value_o, mem_wdata_o, carry_flag_o, auxiliary_carry_flag_o, zero_flag_o,
             overflow_flag_o, global_interrupt_enable_o}), 39'h0);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  task automatic complete_run();
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    complete_run();
  end

  // Main sequence
  initial begin
    logic [7:0] m;
    // Flag inputs and the take marker belong to their own clocked processes
    {nrst_i, issue_i, op_i, bit_sel_i, mem_rdata_i, stack_top_i} = '0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(1237));
    do_reset();
    run_op(5'h0C, 8'h01, 3'h0);
    run_op(5'h0D, 8'h01, 3'h0);
    run_op(5'h10, 8'hFF, 3'h0);
    run_op(5'h11, 8'hFF, 3'h0);
    run_op(5'h12, 8'h80, 3'h7);
    run_op(5'h01, 8'h00, 3'h0);
    // Back-to-back random traffic, boundary bytes weighted in, reset in mid-run
    for (int i = 0; i < 400; i++) begin
      case ($urandom_range(0, 5))
        0: m = 8'h00;
        1: m = 8'h01;
        2: m = 8'hFF;
        default: m = 8'($urandom);
      endcase
      if (i == 200 || $urandom_range(0, 7) == 0) idle();
      if (i == 200) do_reset();
      run_op(5'($urandom_range(0, 18)), m, 3'($urandom));
    end
    idle();
    idle();
    complete_run();
  end
endmodule : rotate_subtract_skip_execution_tb_top

`default_nettype wire
